// *** design/pcc_consts.vh ***
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PCC_ADDR_W             32
`define PCC_PLL_CONFIG_ADDR    32'hA0900188

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PCC_STAT_BYPASS_BIT    25
`define PCC_STAT_DIV_HI        24
`define PCC_STAT_DIV_LO        23
`define PCC_STAT_PUMP_HI       22
`define PCC_STAT_PUMP_LO       21
`define PCC_STAT_MULT_HI       20
`define PCC_STAT_MULT_LO       16
`define PCC_TRIGGER_BIT        15
`define PCC_SEL_BYPASS_BIT     9
`define PCC_SEL_DIV_HI         8
`define PCC_SEL_DIV_LO         7
`define PCC_SEL_PUMP_HI        6
`define PCC_SEL_PUMP_LO        5
`define PCC_SEL_MULT_HI        4
`define PCC_SEL_MULT_LO        0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PCC_RST_BYPASS         1'h0
`define PCC_RST_DIV            2'h0
`define PCC_RST_PUMP           2'h3
`define PCC_RST_MULT           5'h1A

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PCC_CLK_PERIOD_NS      10
`define PCC_CHANGE_TIME_NS     4000000
`define PCC_CHANGE_CYCLES      (`PCC_CHANGE_TIME_NS / `PCC_CLK_PERIOD_NS)
`define PCC_SETTLE_CYCLES      16
`define PCC_CNT_W              20

`endif

// *** design/pcc_pll_config.v ***
// Summary of operation
// - Writing one to trigger while no change runs applies the bypass, divider, pump, multiplier settings written with it.
// - After a triggered change without bypass the system stays in reset until lock and settling.
// - With bypass selected the change and its reset happen at once.
// - Without bypass the change and its reset take 4 ms.
// - Bypass select: zero runs the PLL, one uses the reference clock; resets zero.
// - Divider select codes 0..3 divide by 1, 2, 4, 8; resets zero.
// - Bypass state shows the strap at power-up, later the applied value.
// - Divider state shows the two strap inputs, later the applied value.
// - Pump current state shows the strap setting, later the applied value.
// - Multiplier state shows five strap inputs, later the applied value.
`include "pcc_consts.vh"

module pcc_pll_config #(
    parameter CHANGE_CYCLES = `PCC_CHANGE_CYCLES
) (
    // Clock and reset
    input  wire                   clk,
    input  wire                   resetn,
    // APB slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`PCC_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    // Strap pins, sampled after reset release
    input  wire                   strap_bypass,
    input  wire [1:0]             strap_divider,
    input  wire [1:0]             strap_pump,
    input  wire [4:0]             strap_multiplier,
    // PLL control and status
    input  wire                   pll_lock,
    output reg                    pll_bypass,
    output reg  [1:0]             pll_divider,
    output reg  [1:0]             pll_pump_current,
    output reg  [4:0]             pll_multiplier,
    output reg                    system_reset_n
);

    // ------------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------------
    // ST_STRAP keeps the system in reset until the strap levels are captured.
    localparam [2:0] ST_STRAP  = 3'h0;
    localparam [2:0] ST_IDLE   = 3'h1;
    localparam [2:0] ST_WAIT   = 3'h2;
    localparam [2:0] ST_LOCK   = 3'h3;
    localparam [2:0] ST_SETTLE = 3'h4;
    localparam [2:0] ST_BYPASS = 3'h5;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // The straps are quasi-static levels captured once, well after they have
    // settled, so one multi-bit synchroniser is safe for them.
    wire [9:0] strap_sync;
    wire       lock_sync;

    pcc_sync2 #(.W(10)) u_strap_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({strap_bypass, strap_divider, strap_pump, strap_multiplier}),
        .q      (strap_sync)
    );

    pcc_sync2 #(.W(1)) u_lock_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (pll_lock),
        .q      (lock_sync)
    );

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg        bypass_select_reg;
    reg [1:0]  output_divider_select_reg;
    reg [1:0]  pump_current_select_reg;
    reg [4:0]  multiplier_select_reg;
    reg        bypass_state_reg;
    reg [1:0]  divider_state_reg;
    reg [1:0]  pump_current_state_reg;
    reg [4:0]  multiplier_state_reg;
    reg [2:0]  state_reg;
    reg [1:0]  strap_cnt_reg;
    reg [4:0]  settle_cnt_reg;
    reg        timer_start_reg;
    wire       timer_done;
    wire       addr_hit;
    wire       wr_access;
    wire       wr_hit;
    wire       apply_change_trigger;

    // ------------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------------
    // A write lands only in the access cycle, in which pready is high, so a
    // setup cycle alone never changes a register.
    assign addr_hit             = (paddr == `PCC_PLL_CONFIG_ADDR);
    assign wr_access            = psel && penable && pwrite && pready;
    assign wr_hit               = wr_access && addr_hit;
    // A trigger that arrives while a change is still running is dropped, so
    // sequences never overlap and each accepted write starts exactly one.
    assign apply_change_trigger = wr_hit && pwdata[`PCC_TRIGGER_BIT]
                                  && (state_reg == ST_IDLE);

    pcc_wait_timer #(.CHANGE_CYCLES(CHANGE_CYCLES)) u_wait_timer (
        .clk    (clk),
        .resetn (resetn),
        .start  (timer_start_reg),
        .done   (timer_done)
    );

    // ------------------------------------------------------------------------
    // APB slave: zero wait states, error on an unmapped address
    // ------------------------------------------------------------------------
    // Read data is taken in the setup cycle so that it stands settled for the
    // whole access cycle; outside it prdata reads as zero.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit;
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite && addr_hit)
            begin
                // The trigger bit and reserved bits read as zero.
                prdata[`PCC_STAT_BYPASS_BIT]                   <= bypass_state_reg;
                prdata[`PCC_STAT_DIV_HI:`PCC_STAT_DIV_LO]      <= divider_state_reg;
                prdata[`PCC_STAT_PUMP_HI:`PCC_STAT_PUMP_LO]    <= pump_current_state_reg;
                prdata[`PCC_STAT_MULT_HI:`PCC_STAT_MULT_LO]    <= multiplier_state_reg;
                prdata[`PCC_SEL_BYPASS_BIT]                    <= bypass_select_reg;
                prdata[`PCC_SEL_DIV_HI:`PCC_SEL_DIV_LO]        <= output_divider_select_reg;
                prdata[`PCC_SEL_PUMP_HI:`PCC_SEL_PUMP_LO]      <= pump_current_select_reg;
                prdata[`PCC_SEL_MULT_HI:`PCC_SEL_MULT_LO]      <= multiplier_select_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Software settings
    // ------------------------------------------------------------------------
    // Selects are written on every mapped write, even while a change runs;
    // the PLL only takes the fields written together with an accepted trigger.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bypass_select_reg         <= `PCC_RST_BYPASS;
            output_divider_select_reg <= `PCC_RST_DIV;
            pump_current_select_reg   <= `PCC_RST_PUMP;
            multiplier_select_reg     <= `PCC_RST_MULT;
        end
        else if (wr_hit)
        begin
            bypass_select_reg         <= pwdata[`PCC_SEL_BYPASS_BIT];
            output_divider_select_reg <= pwdata[`PCC_SEL_DIV_HI:`PCC_SEL_DIV_LO];
            pump_current_select_reg   <= pwdata[`PCC_SEL_PUMP_HI:`PCC_SEL_PUMP_LO];
            multiplier_select_reg     <= pwdata[`PCC_SEL_MULT_HI:`PCC_SEL_MULT_LO];
        end
    end

    // ------------------------------------------------------------------------
    // Change sequencer
    // ------------------------------------------------------------------------
    // Settings written together with the trigger are applied, since the
    // trigger acts on the word being written.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg              <= ST_STRAP;
            strap_cnt_reg          <= 2'h0;
            settle_cnt_reg         <= 5'h00;
            timer_start_reg        <= 1'b0;
            bypass_state_reg       <= `PCC_RST_BYPASS;
            divider_state_reg      <= `PCC_RST_DIV;
            pump_current_state_reg <= `PCC_RST_PUMP;
            multiplier_state_reg   <= `PCC_RST_MULT;
            system_reset_n         <= 1'b0;
        end
        else
        begin
            timer_start_reg <= 1'b0;
            case (state_reg)
                ST_STRAP:
                begin
                    // Straps need two edges to pass the synchroniser.
                    strap_cnt_reg <= strap_cnt_reg + 2'h1;
                    if (strap_cnt_reg == 2'h2)
                    begin
                        bypass_state_reg       <= strap_sync[9];
                        divider_state_reg      <= strap_sync[8:7];
                        pump_current_state_reg <= strap_sync[6:5];
                        multiplier_state_reg   <= strap_sync[4:0];
                        system_reset_n         <= 1'b1;
                        state_reg              <= ST_IDLE;
                    end
                end
                ST_IDLE:
                begin
                    if (apply_change_trigger)
                    begin
                        bypass_state_reg       <= pwdata[`PCC_SEL_BYPASS_BIT];
                        divider_state_reg      <= pwdata[`PCC_SEL_DIV_HI:`PCC_SEL_DIV_LO];
                        pump_current_state_reg <= pwdata[`PCC_SEL_PUMP_HI:`PCC_SEL_PUMP_LO];
                        multiplier_state_reg   <= pwdata[`PCC_SEL_MULT_HI:`PCC_SEL_MULT_LO];
                        system_reset_n         <= 1'b0;
                        if (pwdata[`PCC_SEL_BYPASS_BIT])
                        begin
                            state_reg <= ST_BYPASS;
                        end
                        else
                        begin
                            timer_start_reg <= 1'b1;
                            state_reg       <= ST_WAIT;
                        end
                    end
                end
                ST_BYPASS:
                begin
                    // One-cycle reset pulse, no wait for lock.
                    system_reset_n <= 1'b1;
                    state_reg      <= ST_IDLE;
                end
                ST_WAIT:
                begin
                    // The full change time passes before lock is looked at, since
                    // the PLL may still report the old lock while it relocks.
                    if (timer_done)
                    begin
                        state_reg <= ST_LOCK;
                    end
                end
                ST_LOCK:
                begin
                    // Lock is trusted only after the synchroniser; the settle count
                    // restarts here on every entry, so settling is always continuous.
                    settle_cnt_reg <= 5'h00;
                    if (lock_sync)
                    begin
                        state_reg <= ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    // Loss of lock while settling restarts the lock wait.
                    if (!lock_sync)
                    begin
                        state_reg <= ST_LOCK;
                    end
                    else if (settle_cnt_reg == `PCC_SETTLE_CYCLES - 1)
                    begin
                        system_reset_n <= 1'b1;
                        state_reg      <= ST_IDLE;
                    end
                    else
                    begin
                        settle_cnt_reg <= settle_cnt_reg + 5'h01;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // PLL drive follows the active settings
    // ------------------------------------------------------------------------
    // Registered copies of the status fields, one cycle behind them, so that
    // every pin towards the PLL comes straight from a flip-flop.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pll_bypass       <= `PCC_RST_BYPASS;
            pll_divider      <= `PCC_RST_DIV;
            pll_pump_current <= `PCC_RST_PUMP;
            pll_multiplier   <= `PCC_RST_MULT;
        end
        else
        begin
            pll_bypass       <= bypass_state_reg;
            pll_divider      <= divider_state_reg;
            pll_pump_current <= pump_current_state_reg;
            pll_multiplier   <= multiplier_state_reg;
        end
    end

endmodule

// *** design/pcc_sync2.v ***
module pcc_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         resetn,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_reg;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// *** design/pcc_wait_timer.v ***
`include "pcc_consts.vh"

module pcc_wait_timer #(
    parameter CHANGE_CYCLES = `PCC_CHANGE_CYCLES
) (
    // Clock and reset
    input  wire clk,
    input  wire resetn,
    // Control
    input  wire start,
    output reg  done
);

    // ------------------------------------------------------------------------
    // Down counter; done is a one-cycle pulse when the count runs out.
    // ------------------------------------------------------------------------
    reg [`PCC_CNT_W-1:0] cnt_reg;
    reg                  run_reg;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= {`PCC_CNT_W{1'b0}};
            run_reg <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_reg <= CHANGE_CYCLES[`PCC_CNT_W-1:0] - 1'b1;
                run_reg <= 1'b1;
            end
            else if (run_reg)
            begin
                if (cnt_reg == {`PCC_CNT_W{1'b0}})
                begin
                    run_reg <= 1'b0;
                    done    <= 1'b1;
                end
                else
                begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end

endmodule

// *** sim/pcc_pll_config_monitor.sv ***
`include "pcc_consts.vh"

module pcc_pll_config_monitor #(
    parameter CHANGE_CYCLES = 20
) (
    // Clock and reset
    input wire        clk,
    input wire        resetn,
    // APB slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Strap pins
    input wire        strap_bypass,
    input wire [1:0]  strap_divider,
    input wire [1:0]  strap_pump,
    input wire [4:0]  strap_multiplier,
    // PLL control and status
    input wire        pll_lock,
    input wire        pll_bypass,
    input wire [1:0]  pll_divider,
    input wire [1:0]  pll_pump_current,
    input wire [4:0]  pll_multiplier,
    input wire        system_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // Counts cycles of system reset, so a too-short change shows at release.
    logic [31:0] lo_cnt_reg;
    wire trig_wr = psel && penable && pwrite && pready && !pslverr && pwdata[15] && system_reset_n;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            lo_cnt_reg <= 32'h0;
        else
            lo_cnt_reg <= system_reset_n ? 32'h0 : lo_cnt_reg + 32'h1;
    end

    a_ready_after_setup: assert property (@(posedge clk) disable iff (!resetn)
        psel && !penable |=> pready) else $error("pready missing after setup");
    a_ready_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
        pready |=> !pready) else $error("pready held too long");
    a_unmapped_error: assert property (@(posedge clk) disable iff (!resetn)
        psel && !penable && paddr != `PCC_PLL_CONFIG_ADDR |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        pready && !pslverr |-> prdata[31:26] == 6'h00 && prdata[15:10] == 6'h00)
        else $error("reserved or trigger bits read nonzero");
    a_apply_settings: assert property (@(posedge clk) disable iff (!resetn)
        trig_wr |=> ##1 pll_bypass == $past(pwdata[9], 2) && pll_divider == $past(pwdata[8:7], 2)
        && pll_pump_current == $past(pwdata[6:5], 2) && pll_multiplier == $past(pwdata[4:0], 2))
        else $error("settings not applied");
    a_hold_in_reset: assert property (@(posedge clk) disable iff (!resetn)
        trig_wr |=> !system_reset_n) else $error("no system reset on change");
    a_bypass_immediate: assert property (@(posedge clk) disable iff (!resetn)
        trig_wr && pwdata[9] |=> !system_reset_n ##1 system_reset_n)
        else $error("bypass change not immediate");
    a_change_time: assert property (@(posedge clk) disable iff (!resetn)
        $rose(system_reset_n) && lo_cnt_reg > 32'h4 |-> lo_cnt_reg >= CHANGE_CYCLES + 15)
        else $error("system reset released too early");
endmodule

bind pcc_pll_config pcc_pll_config_monitor #(.CHANGE_CYCLES(CHANGE_CYCLES)) u_mon (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_bypass(strap_bypass), .strap_divider(strap_divider), .strap_pump(strap_pump),
    .strap_multiplier(strap_multiplier), .pll_lock(pll_lock), .pll_bypass(pll_bypass),
    .pll_divider(pll_divider), .pll_pump_current(pll_pump_current),
    .pll_multiplier(pll_multiplier), .system_reset_n(system_reset_n));

// *** sim/tb_top.sv ***
`include "pcc_consts.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CC = 20;
    localparam logic [31:0] A = `PCC_PLL_CONFIG_ADDR;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, sb, lock, pb, srn, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [1:0]  sd, sp, pd, pp;
    logic [4:0]  sm, pm;
    logic [9:0]  s;
    int          n_mismatch, total_checks, i, n;

    pcc_pll_config #(.CHANGE_CYCLES(CC)) dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_bypass(sb), .strap_divider(sd), .strap_pump(sp), .strap_multiplier(sm),
        .pll_lock(lock), .pll_bypass(pb), .pll_divider(pd), .pll_pump_current(pp),
        .pll_multiplier(pm), .system_reset_n(srn));

    function automatic logic [31:0] word(input logic [9:0] st, input logic [9:0] sel);
        return {6'h00, st, 1'b0, 5'h00, sel};
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is seen at an edge; no wait-state count assumed.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k == 50)
            n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #50000;
        n_mismatch++;
        tally_and_finish;
    end

    initial
    begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sb, sd, sp, sm} = {1'b1, 2'h2, 2'h1, 5'h0B};
        lock = 1'b1;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        xfer(1'b0, A, 32'h0);
        check(rd, word(10'h32B, 10'h07A));
        check({pb, pd, pp, pm}, 10'h32B);
        check(srn, 1'b1);
        $display("test powerup done");
        xfer(1'b1, A, 32'hFC00_7ECF);
        xfer(1'b0, A, 32'h0);
        check(rd, word(10'h32B, 10'h2CF));
        check({srn, pb, pd, pp, pm}, 11'h72B);
        $display("test plain write done");
        for (i = 0; i < 4; i++)
        begin
            s = {1'b1, 2'(3 - i), i[1:0], 5'(i * 7)};
            xfer(1'b1, A, {16'h0001, 6'h00, s} << 15 >> 15 | 32'h8000 | s);
            xfer(1'b0, A, 32'h0);
            check(rd, word(s, s));
            check({srn, pb, pd, pp, pm}, {1'b1, s});
        end
        $display("test bypass change done");
        lock <= 1'b0;
        s = 10'h14C;
        xfer(1'b1, A, 32'h8000 | s);
        xfer(1'b1, A, 32'h0000_83FF);
        repeat (CC + 10) @(posedge clk);
        check(srn, 1'b0);
        lock <= 1'b1;
        n = 0;
        while (srn !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        check(n >= 16 && n < 200, 1'b1);
        xfer(1'b0, A, 32'h0);
        check(rd, word(s, 10'h3FF));
        check({pb, pd, pp, pm}, s);
        $display("test locked change done");
        xfer(1'b1, A + 32'h4, 32'h0000_8000);
        check({err, srn}, 2'h3);
        xfer(1'b0, A + 32'h4, 32'h0);
        check({err, srn, rd}, {2'h3, 32'h0});
        xfer(1'b0, A, 32'h0);
        check({err, rd}, {1'b0, word(s, 10'h3FF)});
        $display("test unmapped done");
        xfer(1'b1, A, 32'h0000_81A4);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (srn !== 1'b1 && n < 200);
        check(n >= CC + 16 && n < CC + 40, 1'b1);
        xfer(1'b0, A, 32'h0);
        check(rd, word(10'h1A4, 10'h1A4));
        check({srn, pb, pd, pp, pm}, {1'b1, 10'h1A4});
        $display("test timed change done");
        tally_and_finish;
    end
endmodule
